// ---- pkg/mdt_pkg.sv ----
package mdt_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MIN_PULSE_MS = 50;
  localparam int POWER_OFF_HOLD_TIME_MS = 100;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIAL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ELAPSED = 8'h0C;
  localparam logic [7:0] ADDR_SETTIME = 8'h10;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RANGE_LSB = 4;
  localparam int CTRL_DOUBLE_BIT = 6;
  localparam int CTRL_NOIN_BIT = 8;
  localparam int CTRL_VOLTIN_BIT = 9;
  localparam int CTRL_TRANS_BIT = 10;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [9:0] DIAL_RESET = 10'h000;
  localparam logic [9:0] DIAL_FULL = 10'h3E8;

  localparam int ST_OUT_BIT = 0;
  localparam int ST_INST_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_GATE_BIT = 3;

  // ---------------------------------------------------------------
  // Operating modes and time ranges
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_ON_DELAY = 3'h0;
  localparam logic [2:0] MODE_FLICK_OFF = 3'h1;
  localparam logic [2:0] MODE_FLICK_ON = 3'h2;
  localparam logic [2:0] MODE_ONOFF_C = 3'h3;
  localparam logic [2:0] MODE_OFF_DELAY = 3'h4;
  localparam logic [2:0] MODE_INTERVAL = 3'h5;
  localparam logic [2:0] MODE_ONOFF_G = 3'h6;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h7;

  // Full-scale spans in tenths of a unit: 1.2, 3, 12 and 30.
  localparam logic [8:0] SPAN_0 = 9'h00C;
  localparam logic [8:0] SPAN_1 = 9'h01E;
  localparam logic [8:0] SPAN_2 = 9'h078;
  localparam logic [8:0] SPAN_3 = 9'h12C;

  function automatic logic [8:0] mdt_span(input logic [1:0] sel);
    logic [8:0] s;
    s = SPAN_0;
    case (sel)
      2'h0: s = SPAN_0;
      2'h1: s = SPAN_1;
      2'h2: s = SPAN_2;
      default: s = SPAN_3;
    endcase
    return s;
  endfunction

endpackage

// ---- verilog/mdt_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
module mdt_tick import mdt_pkg::*; #(
  parameter int CYCLES = TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Time base
  output logic tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mdt_tick_st_t;

  mdt_tick_st_t st_r, st_nxt;

  // ---------------------------------------------------------------
  // Free-running divider
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= 32'(CYCLES - 1)) begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule
`default_nettype wire

// ---- verilog/mdt_setpoint.sv ----
`timescale 1ns/1ps
`default_nettype none
module mdt_setpoint import mdt_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Dial settings
  input wire logic [9:0] dial,
  input wire logic [1:0] range_sel,
  input wire logic dbl,
  // Set time in ticks
  output logic [19:0] set_ticks
);

  typedef struct packed {
    logic [19:0] ticks;
  } mdt_sp_st_t;

  mdt_sp_st_t st_r, st_nxt;
  logic [18:0] prod;
  logic [19:0] base;

  // ---------------------------------------------------------------
  // Dial position to set time
  // ---------------------------------------------------------------
  // The dial is in thousandths of full scale and the tick is 1 ms, so
  // the set time in ticks is dial * span_tenths / 10, doubled when dbl is set.
  always_comb begin
    prod = 19'(dial) * 19'(mdt_span(range_sel));
    base = 20'(prod / 19'h0000A);
    st_nxt.ticks = dbl ? {base[18:0], 1'b0} : base;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign set_ticks = st_r.ticks;

endmodule
`default_nettype wire

// ---- verilog/mdt_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module mdt_timer import mdt_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int ELAPSED_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field inputs
  input wire logic supply_on,
  input wire logic start_in,
  input wire logic reset_in,
  input wire logic gate_in,
  // Load outputs
  output logic ctrl_out,
  output logic inst_out
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_DONE = 3'b100
  } mdt_state_t;

  typedef struct packed {
    logic [10:0] ctrl;
    logic [9:0] dial;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic supply_d;
    logic start_d;
    mdt_state_t state;
    logic [ELAPSED_W-1:0] elapsed;
    logic target;
    logic out;
    logic inst;
  } mdt_st_t;

  mdt_st_t st_r, st_nxt;

  logic tick;
  logic [19:0] set_ticks;
  logic [2:0] mode;
  logic no_inputs;
  logic volt_in;
  logic trans_out;
  logic start_ev;
  logic power_ev;
  logic fall_ev;
  logic clear;
  logic gated;
  logic expired;
  logic setup;
  logic access;

  // ---------------------------------------------------------------
  // Time base and set time
  // ---------------------------------------------------------------
  mdt_tick #(
    .CYCLES(TICK_CYC)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  mdt_setpoint u_setpoint (
    .pclk(pclk),
    .presetn(presetn),
    .dial(st_r.dial),
    .range_sel(st_r.ctrl[CTRL_RANGE_LSB +: 2]),
    .dbl(st_r.ctrl[CTRL_DOUBLE_BIT]),
    .set_ticks(set_ticks)
  );

  // ---------------------------------------------------------------
  // Input qualification
  // ---------------------------------------------------------------
  // Pins are sampled on every clock, so any pulse of 50 ms is seen
  // five million times over; no filter is needed to catch it.
  assign mode = st_r.ctrl[CTRL_MODE_LSB +: 3];
  assign no_inputs = st_r.ctrl[CTRL_NOIN_BIT];
  assign volt_in = st_r.ctrl[CTRL_VOLTIN_BIT];
  assign trans_out = st_r.ctrl[CTRL_TRANS_BIT];

  // Power removal behaves as a reset of the timing state.
  assign clear = !supply_on || (reset_in && !volt_in && !no_inputs);
  assign gated = gate_in && !volt_in && !no_inputs;
  assign start_ev = start_in && !st_r.start_d && !no_inputs;
  assign fall_ev = !start_in && st_r.start_d && !no_inputs;
  assign power_ev = supply_on && !st_r.supply_d;
  assign expired = (st_r.elapsed >= ELAPSED_W'(set_ticks));

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable && st_r.pready;

  function automatic logic mdt_mapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_DIAL) || (a == ADDR_STATUS) ||
           (a == ADDR_ELAPSED) || (a == ADDR_SETTIME);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.supply_d = supply_on;
    st_nxt.start_d = start_in;

    // Register bus: one wait-free access phase after each setup.
    if (setup) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !mdt_mapped(paddr);
      st_nxt.prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          ADDR_CTRL: st_nxt.prdata = {21'h000000, st_r.ctrl};
          ADDR_DIAL: st_nxt.prdata = {22'h000000, st_r.dial};
          ADDR_STATUS: st_nxt.prdata = {28'h0000000, gated,
                                        st_r.state == S_RUN,
                                        st_r.inst, st_r.out};
          ADDR_ELAPSED: st_nxt.prdata = 32'(st_r.elapsed);
          ADDR_SETTIME: st_nxt.prdata = {12'h000, set_ticks};
          default: st_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (access && pwrite) begin
      case (paddr)
        ADDR_CTRL: st_nxt.ctrl = pwdata[10:0];
        ADDR_DIAL: st_nxt.dial = (pwdata[9:0] > DIAL_FULL) ? DIAL_FULL : pwdata[9:0];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end

    // Timing engine.
    if (clear) begin
      st_nxt.state = S_IDLE;
      st_nxt.elapsed = '0;
      st_nxt.out = 1'b0;
      st_nxt.target = 1'b0;
    end else if (start_ev || (power_ev && mode != MODE_ONOFF_C &&
                 mode != MODE_ONOFF_G && mode != MODE_OFF_DELAY)) begin
      // Start is honoured even under gate; gate only freezes counting.
      st_nxt.elapsed = '0;
      st_nxt.state = S_RUN;
      case (mode)
        MODE_ON_DELAY: begin
          st_nxt.out = 1'b0;
          st_nxt.target = 1'b1;
        end
        MODE_FLICK_OFF: begin
          st_nxt.out = 1'b0;
          st_nxt.target = 1'b1;
        end
        MODE_FLICK_ON: begin
          st_nxt.out = 1'b1;
          st_nxt.target = 1'b0;
        end
        MODE_ONOFF_C, MODE_ONOFF_G: begin
          st_nxt.target = 1'b1;
        end
        MODE_OFF_DELAY: begin
          st_nxt.out = 1'b1;
          st_nxt.target = 1'b0;
          st_nxt.state = S_DONE;
        end
        MODE_INTERVAL, MODE_ONE_SHOT: begin
          st_nxt.out = 1'b1;
          st_nxt.target = 1'b0;
        end
        default: st_nxt.target = 1'b1;
      endcase
    end else if (fall_ev && (mode == MODE_OFF_DELAY || mode == MODE_ONOFF_C ||
                 mode == MODE_ONOFF_G)) begin
      // Signal release times the off phase.
      st_nxt.elapsed = '0;
      st_nxt.target = 1'b0;
      st_nxt.state = S_RUN;
    end else begin
      case (st_r.state)
        S_IDLE: st_nxt.elapsed = '0;
        S_RUN: begin
          if (expired) begin
            st_nxt.out = st_r.target;
            if (mode == MODE_FLICK_OFF || mode == MODE_FLICK_ON) begin
              st_nxt.target = !st_r.target;
              st_nxt.elapsed = '0;
            end else begin
              // Finished until the next start edge, or the release edge in the off-delay and on-off modes, so a held start
              // cannot fire the output a second time.
              st_nxt.state = S_DONE;
            end
          end else if (tick && !gated) begin
            st_nxt.elapsed = st_r.elapsed + ELAPSED_W'(1);
          end
        end
        S_DONE: st_nxt.elapsed = st_r.elapsed;
        default: st_nxt.state = S_IDLE;
      endcase
    end

    // Instantaneous contact follows activity since the start event; the transistor variant (trans_out) keeps it off.
    st_nxt.inst = (st_nxt.state != S_IDLE) && !trans_out;
    if (trans_out && st_nxt.state == S_IDLE) begin
      st_nxt.out = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.ctrl <= CTRL_RESET;
      st_r.dial <= DIAL_RESET;
      st_r.prdata <= 32'h0000_0000;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.supply_d <= 1'b0;
      st_r.start_d <= 1'b0;
      st_r.state <= S_IDLE;
      st_r.elapsed <= '0;
      st_r.target <= 1'b0;
      st_r.out <= 1'b0;
      st_r.inst <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign ctrl_out = st_r.out;
  assign inst_out = st_r.inst;

endmodule
`default_nettype wire

// ---- test/mdt_timer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module mdt_timer_properties import mdt_pkg::*; #(
  parameter int TICK_CYC = 10,
  parameter int ELAPSED_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Field lines
  input wire logic supply_on,
  input wire logic start_in,
  input wire logic reset_in,
  input wire logic gate_in,
  input wire logic ctrl_out,
  input wire logic inst_out
);
  // ----------------------------------------
  // Shadow of the written settings
  // ----------------------------------------
  logic [10:0] ctrl_r;
  logic [9:0] dial_r;
  logic [2:0] md;
  logic st_r, wr, live, go;
  assign md = ctrl_r[2:0];
  assign wr = psel && penable && pready && pwrite;
  // Signal inputs are only checked on the plain variant with power applied.
  assign live = supply_on && ctrl_r[9:8] == 2'h0;
  assign go = live && start_in && !st_r && !reset_in;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      dial_r <= DIAL_RESET;
      st_r <= 1'b0;
    end else begin
      st_r <= start_in;
      if (wr && paddr == ADDR_CTRL) ctrl_r <= pwdata[10:0];
      if (wr && paddr == ADDR_DIAL) dial_r <= pwdata[9:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_map: assert property (pready |-> pslverr == !(paddr == ADDR_CTRL ||
    paddr == ADDR_DIAL || paddr == ADDR_STATUS || paddr == ADDR_ELAPSED ||
    paddr == ADDR_SETTIME))
    else $error("bad error flag");
  a_power_clears: assert property (!supply_on |=> !ctrl_out && !inst_out)
    else $error("outputs kept without power");
  a_reset_clears: assert property (reset_in && live |=> !ctrl_out && !inst_out)
    else $error("outputs kept in reset");
  a_trans_noinst: assert property (ctrl_r[10] && $past(ctrl_r[10]) |-> !inst_out)
    else $error("instant output on transistor variant");
  a_start_runs: assert property (go && md == MODE_ON_DELAY && !ctrl_r[10] |=> inst_out)
    else $error("start ignored");
  a_zero_instant: assert property (go && md == MODE_ON_DELAY && dial_r == 10'h000
    |-> ##[1:3] ctrl_out) else $error("zero set time not instant");
  a_interval_on: assert property (go && md == MODE_INTERVAL |-> ##[1:2] ctrl_out)
    else $error("interval output late");
  a_gate_holds: assert property (gate_in && live && $past(gate_in) && $past(gate_in, 2)
    && md == MODE_ON_DELAY && dial_r != 10'h000 && !ctrl_out |=> !ctrl_out)
    else $error("output rose while gated");
endmodule
bind mdt_timer mdt_timer_properties #(.TICK_CYC(TICK_CYC), .ELAPSED_W(ELAPSED_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .supply_on(supply_on), .start_in(start_in), .reset_in(reset_in), .gate_in(gate_in),
  .ctrl_out(ctrl_out), .inst_out(inst_out));
`default_nettype wire

// ---- test/mdt_field_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mdt_field_model import mdt_pkg::*; #(
  parameter int TICK = 10
) (
  // Clock
  input wire logic pclk,
  // Field lines
  output logic supply_on,
  output logic start_in,
  output logic reset_in,
  output logic gate_in
);
  initial {supply_on, start_in, reset_in, gate_in} = 4'h0;
  task automatic wait_ms(input int n);
    repeat (n * TICK) @(posedge pclk);
  endtask
  task automatic set_line(input int sel, input logic v);
    @(posedge pclk);
    case (sel)
      0: supply_on <= v;
      1: start_in <= v;
      2: reset_in <= v;
      default: gate_in <= v;
    endcase
  endtask
  // A real contact is never shorter than the minimum pulse, so short requests are stretched.
  task automatic pulse(input int sel, input int n);
    set_line(sel, 1'b1);
    wait_ms((n < MIN_PULSE_MS) ? MIN_PULSE_MS : n);
    set_line(sel, 1'b0);
  endtask
  // The supply stays off for the full hold time so the timer forgets its state.
  task automatic power_cycle;
    set_line(0, 1'b0);
    wait_ms(POWER_OFF_HOLD_TIME_MS);
    set_line(0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb import mdt_pkg::*;;
  localparam int TK = 10;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, last = 1'b0;
  logic supply_on, start_in, reset_in, gate_in, ctrl_out, inst_out;
  int miscompares = 0;
  int n_checks = 0;
  int rises = 0;
  always #5 pclk = ~pclk;
  // Counting on the falling edge keeps the count clear of the output flop update.
  always @(negedge pclk) begin
    if (ctrl_out === 1'b1 && last !== 1'b1) rises++;
    last = ctrl_out;
  end
  mdt_field_model #(.TICK(TK)) u_field (.pclk(pclk), .supply_on(supply_on),
    .start_in(start_in), .reset_in(reset_in), .gate_in(gate_in));
  mdt_timer #(.TICK_CYC(TK), .ELAPSED_W(24)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_on(supply_on),
    .start_in(start_in), .reset_in(reset_in), .gate_in(gate_in),
    .ctrl_out(ctrl_out), .inst_out(inst_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Look at the answer mid-cycle, where it has settled, then let the sampling edge pass.
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic co(input logic e);
    @(negedge pclk);
    check({31'h0, ctrl_out}, {31'h0, e});
  endtask
  task automatic ci(input logic e);
    @(negedge pclk);
    check({31'h0, inst_out}, {31'h0, e});
  endtask
  task automatic setup(input logic [31:0] c, input logic [31:0] d);
    u_field.pulse(2, 50);
    apb(1'b1, ADDR_CTRL, c);
    apb(1'b1, ADDR_DIAL, d);
    rises = 0;
  endtask
  task automatic t_regs;
    int span[4] = '{12, 30, 120, 300};
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_DIAL, 32'h0);
    apb(1'b1, ADDR_DIAL, 32'h1F4);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ADDR_CTRL, 32'(r << CTRL_RANGE_LSB));
      rchk(ADDR_SETTIME, 32'(500 * span[r] / 10));
    end
    apb(1'b1, ADDR_CTRL, 32'h70);
    rchk(ADDR_SETTIME, 32'h7530);
    rchk(8'h20, 32'h0);
    check({31'h0, er}, 32'h1);
  endtask
  task automatic t_ondelay;
    logic [31:0] held;
    setup(32'h0, 32'h64);
    u_field.set_line(0, 1'b1);
    u_field.wait_ms(60);
    u_field.set_line(3, 1'b1);
    u_field.wait_ms(5);
    apb(1'b0, ADDR_ELAPSED, 32'h0);
    held = rd;
    u_field.wait_ms(100);
    rchk(ADDR_ELAPSED, held);
    u_field.set_line(3, 1'b0);
    u_field.wait_ms(50);
    co(1'b0);
    u_field.wait_ms(20);
    co(1'b1);
    u_field.set_line(3, 1'b1);
    u_field.pulse(2, 50);
    rchk(ADDR_ELAPSED, 32'h0);
    co(1'b0);
    u_field.pulse(1, 50);
    ci(1'b1);
    u_field.set_line(3, 1'b0);
    u_field.wait_ms(130);
    co(1'b1);
  endtask
  task automatic t_flicker;
    for (int m = 1; m < 3; m++) begin
      setup(32'(m), 32'h32);
      u_field.pulse(1, 50);
      u_field.wait_ms(450);
      check(32'(rises > 2), 32'h1);
      u_field.pulse(2, 50);
      co(1'b0);
      rises = 0;
      u_field.wait_ms(200);
      check(32'(rises), 32'h0);
    end
  endtask
  task automatic t_signal;
    logic [2:0] md[3] = '{MODE_ONOFF_C, MODE_OFF_DELAY, MODE_ONOFF_G};
    foreach (md[i]) begin
      setup({29'h0, md[i]}, 32'h64);
      u_field.set_line(1, 1'b1);
      u_field.wait_ms(5);
      co(md[i] == MODE_OFF_DELAY);
      u_field.wait_ms(195);
      co(1'b1);
      u_field.set_line(1, 1'b0);
      u_field.wait_ms(60);
      co(1'b1);
      u_field.wait_ms(80);
      co(1'b0);
    end
  endtask
  task automatic t_shots;
    setup({29'h0, MODE_ONE_SHOT}, 32'h64);
    u_field.pulse(1, 300);
    u_field.wait_ms(200);
    check(32'(rises), 32'h1);
    setup({29'h0, MODE_INTERVAL}, 32'h64);
    u_field.pulse(1, 50);
    co(1'b1);
    u_field.wait_ms(90);
    co(1'b0);
    u_field.pulse(1, 50);
    check(32'(rises), 32'h2);
  endtask
  task automatic t_variants;
    setup(32'h0, 32'h0);
    u_field.pulse(1, 50);
    co(1'b1);
    setup(32'h200, 32'h0);
    u_field.pulse(1, 50);
    u_field.pulse(2, 50);
    co(1'b1);
    setup(32'h405, 32'h64);
    u_field.pulse(1, 50);
    ci(1'b0);
    setup(32'h107, 32'h64);
    u_field.power_cycle();
    u_field.wait_ms(400);
    check(32'(rises), 32'h1);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ondelay();
    t_flicker();
    t_signal();
    t_shots();
    t_variants();
    finish_test();
  end
endmodule
`default_nettype wire
